/* common/smc_pkg.sv */
// Package of offsets, field positions, reset values and timing for the stepper configuration block.
package smc_pkg;

  // ==========================================================================
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_MODULE_CFG   = 8'h00;
  localparam logic [7:0] OFS_SYNC_CFG     = 8'h04;
  localparam logic [7:0] OFS_SETTLE       = 8'h08;
  localparam logic [7:0] OFS_TURN_OFF     = 8'h0c;
  localparam logic [7:0] OFS_HOLD_CUR     = 8'h10;
  localparam logic [7:0] OFS_NOM_CUR      = 8'h14;
  localparam logic [7:0] OFS_MAX_CUR      = 8'h18;
  localparam logic [7:0] OFS_HOLD_RB      = 8'h1c;
  localparam logic [7:0] OFS_NOM_RB       = 8'h20;
  localparam logic [7:0] OFS_MAX_RB       = 8'h24;
  localparam logic [7:0] OFS_CONTROL      = 8'h28;
  localparam logic [7:0] OFS_STATE        = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h34;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h38;

  // ==========================================================================
  // Field positions and writable masks.
  localparam int          MC_COUNTER_MODE_BIT = 0;
  localparam int          MC_XFER_LSB         = 3;
  localparam int          MC_RES_LSB          = 5;
  localparam logic [15:0] MC_WRITE_MASK       = 16'h0079;
  localparam int          SC_TRIG_EDGE_BIT    = 0;
  localparam int          SC_LIFESIGN_BIT     = 6;
  localparam int          SC_INFO_BIT         = 7;
  localparam logic [7:0]  SC_WRITE_MASK       = 8'hc1;
  localparam int          CTRL_RESTART_BIT    = 8;

  // Interrupt event bit positions.
  localparam int IRQ_DRIVE_OK  = 0;
  localparam int IRQ_TRIP      = 1;
  localparam int IRQ_MOTOR_OFF = 2;
  localparam int IRQ_W         = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] RST_MODULE_CFG = 16'h0000;
  localparam logic [7:0]  RST_SYNC_CFG   = 8'h00;
  localparam logic [7:0]  RST_SETTLE     = 8'h01;
  localparam logic [7:0]  RST_TURN_OFF   = 8'h01;
  localparam logic [7:0]  RST_CURRENT    = 8'h00;

  // Fixed codes forced while the sync information is enabled, plus the current and settling limits.
  localparam logic [1:0]  SYNC_XFER_CODE = 2'h0;
  localparam logic [1:0]  SYNC_RES_CODE  = 2'h3;
  localparam logic [7:0]  CURRENT_LIMIT  = 8'h78;
  localparam logic [7:0]  SETTLE_MIN     = 8'h01;

  // ==========================================================================
  // Timing.
  localparam int CLK_MHZ             = 250;
  localparam int SETTLE_UNIT_MS      = 10;
  localparam int TURN_OFF_UNIT_MS    = 100;
  localparam int TICK_CYCLES         = SETTLE_UNIT_MS * CLK_MHZ * 1000;
  localparam int TICKS_PER_OFF_UNIT  = TURN_OFF_UNIT_MS / SETTLE_UNIT_MS;

  // Lifesign shutdown sequence states.
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_DECEL = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_OFF   = 4'b1000
  } smc_state_t;

endpackage

/* sim/smc_config_chk.sv */
// Port checker of the stepper configuration block.
`timescale 1ns/1ps
`default_nettype none
module smc_config_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        motor_energised_i,
  input wire logic        module_ok_i,
  input wire logic [13:0] position_i,
  input wire logic [2:0]  transfer_values_o,
  input wire logic [3:0]  microstep_bits_o,
  input wire logic [7:0]  microstep_o,
  input wire logic [8:0]  fullstep_o,
  input wire logic        extra_regs_visible_o,
  input wire logic        drive_ok_o,
  input wire logic        encoder_ok_o,
  input wire logic        motor_off_o,
  input wire logic [7:0]  current_pct_o
);
  // ==========================================================
  // Properties; guards on past values keep reset leftovers out.
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_once: assert property (s_req |=> s_ack)
    else $error("ack timing");
  chk_split_pos: assert property (!$past(rst_i) && $stable(microstep_bits_o)
    && $past(microstep_bits_o, 2) == microstep_bits_o
    |-> microstep_o == 8'($past(position_i) & ~(14'h3fff << microstep_bits_o))
    && fullstep_o == 9'($past(position_i) >> microstep_bits_o))
    else $error("position split");
  chk_sync_fmt: assert property ($past(extra_regs_visible_o) && extra_regs_visible_o
    |-> transfer_values_o == 3'h1 && microstep_bits_o == 4'h8)
    else $error("sync format");
  chk_enc_mirror: assert property ($past(extra_regs_visible_o) && extra_regs_visible_o
    |-> encoder_ok_o == $past(module_ok_i))
    else $error("encoder ok");
  chk_drive_drop: assert property (!motor_energised_i |=> !drive_ok_o)
    else $error("drive ok stayed");
  chk_off_quiet: assert property ($past(motor_off_o) && motor_off_o
    |-> !drive_ok_o && current_pct_o == 8'h00)
    else $error("motor off active");
  chk_cur_limit: assert property (current_pct_o <= 8'h78)
    else $error("current limit");
  chk_fmt_legal: assert property (transfer_values_o inside {3'h1, 3'h2, 3'h4})
    else $error("transfer count");
endmodule
bind smc_config smc_config_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .motor_energised_i, .module_ok_i, .position_i, .transfer_values_o, .microstep_bits_o,
  .microstep_o, .fullstep_o, .extra_regs_visible_o, .drive_ok_o, .encoder_ok_o,
  .motor_off_o, .current_pct_o);
`default_nettype wire

/* sim/smc_config_tb_top.sv */
// Self-checking bench of the stepper configuration block.
`timescale 1ns/1ps
`default_nettype none
module smc_config_tb_top;
  // ==========================================================
  // Bench signals; the tick is shortened to 8 cycles.
  localparam int TCK = 8;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic        motor_energised_i = 0, motor_standstill_i, motor_accelerating_i = 0;
  logic        module_ok_i = 1, lifesign_expired_i = 0, run = 0, counter_mode_o;
  logic        trigger_falling_o, extra_regs_visible_o, lifesign_enabled_o, drive_ok_o;
  logic        encoder_ok_o, speed_zero_o, motor_off_o, irq_o;
  logic [1:0]  setting_current_sel_i = 0;
  logic [2:0]  transfer_values_o;
  logic [3:0]  wb_sel_i = 4'hf, microstep_bits_o;
  logic [7:0]  wb_adr_i = 0, microstep_o, current_pct_o;
  logic [8:0]  fullstep_o;
  logic [13:0] position_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  int          fail_count = 0, n_compared = 0, seed = 56230, n, mb, v, cv[3];
  int          ce[6] = '{1, 0, 1, 2, 2, 0};
  smc_config #(.TICK_CYCLES(TCK)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .motor_energised_i,
    .motor_standstill_i, .motor_accelerating_i, .module_ok_i, .lifesign_expired_i,
    .setting_current_sel_i, .position_i, .transfer_values_o, .microstep_bits_o,
    .microstep_o, .fullstep_o, .counter_mode_o, .trigger_falling_o, .extra_regs_visible_o,
    .lifesign_enabled_o, .drive_ok_o, .encoder_ok_o, .speed_zero_o, .motor_off_o,
    .current_pct_o, .irq_o);
  smc_motion_model mot_u (.clk_i, .speed_zero_i(speed_zero_o), .run_i(run),
    .standstill_o(motor_standstill_i));
  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait step, so a hung handshake cannot stall the run.
  task automatic tick;
    @(posedge clk_i);
    n++;
    if (n > 3000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // Classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do tick(); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Main sequence: registers, formats, currents, settling, then a lifesign trip.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 8; i++) begin
      wb(0, (i == 7) ? 8'h3c : 8'(4 * i), 0);
      chk("reset", q, (i == 2 || i == 3) ? 1 : 0);
    end
    for (int c = 0; c < 16; c++) begin
      v = $random(seed);
      v[6:3] = c[3:0];
      wb(1, 8'h00, v);
      wb(0, 8'h00, 0);
      chk("cfg", q, v & 32'h79);
      position_i <= 14'($random(seed));
      repeat (2) @(posedge clk_i);
      mb = 5 + c[3:2];
      chk("xfer", transfer_values_o, (c[1:0] == 1) ? 2 : (c[1:0] == 2) ? 4 : 1);
      chk("mbits", microstep_bits_o, mb);
      chk("split", {fullstep_o, microstep_o}, {9'(position_i >> mb), 8'(position_i % (1 << mb))});
      chk("cmode", counter_mode_o, v[0]);
    end
    for (int i = 0; i < 3; i++) begin
      cv[i] = (i == 1) ? 121 : {$random(seed)} % 256;
      wb(1, 8'(16 + 4 * i), cv[i]);
      wb(0, 8'(28 + 4 * i), 0);
      cv[i] = (cv[i] > 120) ? 120 : cv[i];
      chk("cur_rb", q, cv[i]);
    end
    for (int m = 0; m < 6; m++) begin
      setting_current_sel_i <= (m < 4) ? 2'(m) : 2'h0;
      motor_accelerating_i <= (m == 4);
      run <= (m != 5);
      repeat (8) @(posedge clk_i);
      chk("cur_sel", current_pct_o, cv[ce[m]]);
    end
    wb(1, 8'h00, 32'h28);
    wb(1, 8'h04, 32'hff);
    wb(0, 8'h04, 0);
    chk("sync_rb", q, 32'hc1);
    chk("xfer_s", {transfer_values_o, microstep_bits_o}, 7'h18);
    chk("vis", {extra_regs_visible_o, trigger_falling_o}, 2'h3);
    chk("life", lifesign_enabled_o, 1);
    module_ok_i <= 0;
    repeat (2) @(posedge clk_i);
    chk("enc", encoder_ok_o, 0);
    module_ok_i <= 1;
    setting_current_sel_i <= 2'h1;
    wb(1, 8'h28, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("cur_ctl", current_pct_o, cv[2]);
    chk("enc_on", encoder_ok_o, 1);
    wb(1, 8'h08, 0);
    wb(0, 8'h08, 0);
    chk("settle0", q, 1);
    wb(1, 8'h08, 32'h3);
    wb(1, 8'h38, 32'h7);
    motor_energised_i <= 1;
    n = 0;
    do tick(); while (drive_ok_o !== 1'b1);
    chk("settle", (n >= 3 * TCK) && (n <= 4 * TCK + 3), 1);
    wb(0, 8'h30, 0);
    chk("stat", {q[30:0], irq_o}, 32'h3);
    wb(1, 8'h38, 0);
    @(posedge clk_i);
    chk("mask", irq_o, 0);
    wb(1, 8'h38, 32'h7);
    wb(1, 8'h34, 32'h7);
    @(posedge clk_i);
    chk("clear", irq_o, 0);
    run <= 1;
    lifesign_expired_i <= 1;
    n = 0;
    do tick(); while (speed_zero_o !== 1'b1);
    @(posedge clk_i);
    chk("dec_cur", current_pct_o, cv[1]);
    n = 0;
    do tick(); while (motor_off_o !== 1'b1);
    chk("off_time", (n > 9 * TCK) && (n <= 11 * TCK + 8), 1);
    wb(0, 8'h30, 0);
    chk("stat2", q, 32'h6);
    lifesign_expired_i <= 0;
    wb(1, 8'h28, 32'h103);
    @(posedge clk_i);
    chk("restart", motor_off_o, 0);
    end_of_test();
  end
endmodule
`default_nettype wire

/* sim/smc_motion_model.sv */
// Motion side model: the motor comes to standstill a few cycles after a stop.
`timescale 1ns/1ps
`default_nettype none
module smc_motion_model (
  input  wire logic clk_i,
  input  wire logic speed_zero_i,
  input  wire logic run_i,
  output logic      standstill_o
);
  // ==========================================================
  // Ramp-down takes three cycles, so a stop is never instant.
  logic [1:0] lag_ff = 2'h0;
  always_ff @(posedge clk_i) begin
    if (run_i && !speed_zero_i) begin
      lag_ff <= 2'h0;
    end else if (lag_ff != 2'h3) begin
      lag_ff <= lag_ff + 2'h1;
    end
  end
  assign standstill_o = (lag_ff == 2'h3);
endmodule
`default_nettype wire

/* verilog/smc_config.sv */
// Configuration, current selection and lifesign shutdown logic of a stepper motor module.
//
// Summary of operation
// - Transfer-count field picks one, two or four step values; code 11 reserved.
// - Resolution field splits the 14-bit position into 5 to 8 microstep bits.
// - Configuration bit 0 selects meaning of counter state bits 2 and 3.
// - With sync information on, act as one value and 8-bit microsteps.
// - Sync configuration bit 7 shows or hides the additional cyclic registers.
// - Sync configuration bit 6 enables lifesign monitoring of controller traffic.
// - With sync information on, encoder-ok always mirrors module-ok.
// - Drive-ok waits the settling time, 10 ms units, 1 to 255.
// - A lifesign trip decelerates the motor to zero speed at nominal current.
// - After deceleration, switch motor off once turn-off delay has elapsed.
// - Nominal current at constant speed, maximum accelerating, holding at standstill.
// - Current settings accept 0 to 120 percent of rated current.
// - Current preset chosen by motor setting bits, or current register with sync.
// - Readback registers return the configured holding, nominal and maximum currents.
`timescale 1ns/1ps
`default_nettype none

module smc_config #(
  parameter int TICK_CYCLES = smc_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Motion side status, all from logic on clk_i.
  input  wire logic        motor_energised_i,
  input  wire logic        motor_standstill_i,
  input  wire logic        motor_accelerating_i,
  input  wire logic        module_ok_i,
  input  wire logic        lifesign_expired_i,
  input  wire logic [1:0]  setting_current_sel_i,
  input  wire logic [13:0] position_i,
  // Effective configuration.
  output logic      [2:0]  transfer_values_o,
  output logic      [3:0]  microstep_bits_o,
  output logic      [7:0]  microstep_o,
  output logic      [8:0]  fullstep_o,
  output logic             counter_mode_o,
  output logic             trigger_falling_o,
  output logic             extra_regs_visible_o,
  output logic             lifesign_enabled_o,
  // Drive control.
  output logic             drive_ok_o,
  output logic             encoder_ok_o,
  output logic             speed_zero_o,
  output logic             motor_off_o,
  output logic      [7:0]  current_pct_o,
  output logic             irq_o
);

  // ==========================================================================
  // Configuration registers.
  localparam int IRQ_W_C = smc_pkg::IRQ_W;

  logic [15:0] module_cfg_ff;
  logic [7:0]  sync_cfg_ff;
  logic [7:0]  settle_ff;
  logic [7:0]  turn_off_ff;
  logic [7:0]  hold_cur_ff;
  logic [7:0]  nom_cur_ff;
  logic [7:0]  max_cur_ff;
  logic [1:0]  sync_cur_sel_ff;
  logic [IRQ_W_C-1:0] irq_status_ff;
  logic [IRQ_W_C-1:0] irq_enable_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  // Bus access decode: a request is served once, in the cycle before ack.
  logic        bus_req;
  logic        wr_en;
  logic [15:0] wmask;
  logic        restart_pulse;

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_en    = bus_req && wb_we_i;
  assign wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign restart_pulse = wr_en && (wb_adr_i == smc_pkg::OFS_CONTROL) && wb_sel_i[1]
                         && wb_dat_i[smc_pkg::CTRL_RESTART_BIT];

  // Clamp a written current to the accepted range.
  function automatic logic [7:0] clamp_current(input logic [7:0] value);
    if (value > smc_pkg::CURRENT_LIMIT) begin
      clamp_current = smc_pkg::CURRENT_LIMIT;
    end else begin
      clamp_current = value;
    end
  endfunction

  // ==========================================================================
  // Acknowledge: one wait state, ack drops the cycle after it was given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // Module and sync configuration, reserved bits masked off on write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      module_cfg_ff <= smc_pkg::RST_MODULE_CFG;
      sync_cfg_ff   <= smc_pkg::RST_SYNC_CFG;
    end else if (wr_en) begin
      if (wb_adr_i == smc_pkg::OFS_MODULE_CFG) begin
        module_cfg_ff <= (module_cfg_ff & ~wmask)
                         | (wb_dat_i[15:0] & wmask & smc_pkg::MC_WRITE_MASK);
      end else if (wb_adr_i == smc_pkg::OFS_SYNC_CFG && wb_sel_i[0]) begin
        sync_cfg_ff <= wb_dat_i[7:0] & smc_pkg::SC_WRITE_MASK;
      end
    end
  end

  // Timing settings; a settling time of zero is outside the range and becomes one unit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_ff   <= smc_pkg::RST_SETTLE;
      turn_off_ff <= smc_pkg::RST_TURN_OFF;
    end else if (wr_en && wb_sel_i[0]) begin
      if (wb_adr_i == smc_pkg::OFS_SETTLE) begin
        settle_ff <= (wb_dat_i[7:0] == 8'h00) ? smc_pkg::SETTLE_MIN : wb_dat_i[7:0];
      end else if (wb_adr_i == smc_pkg::OFS_TURN_OFF) begin
        turn_off_ff <= wb_dat_i[7:0];
      end
    end
  end

  // Current presets, clamped so the bridge is never asked for more than its maximum.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cur_ff <= smc_pkg::RST_CURRENT;
      nom_cur_ff  <= smc_pkg::RST_CURRENT;
      max_cur_ff  <= smc_pkg::RST_CURRENT;
    end else if (wr_en && wb_sel_i[0]) begin
      if (wb_adr_i == smc_pkg::OFS_HOLD_CUR) begin
        hold_cur_ff <= clamp_current(wb_dat_i[7:0]);
      end else if (wb_adr_i == smc_pkg::OFS_NOM_CUR) begin
        nom_cur_ff <= clamp_current(wb_dat_i[7:0]);
      end else if (wb_adr_i == smc_pkg::OFS_MAX_CUR) begin
        max_cur_ff <= clamp_current(wb_dat_i[7:0]);
      end
    end
  end

  // Motor current selection used while sync information is enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cur_sel_ff <= 2'h0;
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == smc_pkg::OFS_CONTROL) begin
      sync_cur_sel_ff <= wb_dat_i[1:0];
    end
  end

  // ==========================================================================
  // Effective configuration.
  logic       sync_info_en;
  logic [1:0] xfer_code;
  logic [1:0] res_code;

  assign sync_info_en = sync_cfg_ff[smc_pkg::SC_INFO_BIT];
  // Sync information overrides the transfer-count and resolution fields written to the module configuration.
  assign xfer_code = sync_info_en ? smc_pkg::SYNC_XFER_CODE
                                  : module_cfg_ff[smc_pkg::MC_XFER_LSB +: 2];
  assign res_code  = sync_info_en ? smc_pkg::SYNC_RES_CODE
                                  : module_cfg_ff[smc_pkg::MC_RES_LSB +: 2];

  // Transfer values and position split; the reserved count code falls back to one value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_values_o <= 3'h1;
      microstep_bits_o  <= 4'h5;
      microstep_o       <= 8'h00;
      fullstep_o        <= 9'h000;
    end else begin
      case (xfer_code)
        2'h1:    transfer_values_o <= 3'h2;
        2'h2:    transfer_values_o <= 3'h4;
        default: transfer_values_o <= 3'h1;
      endcase
      microstep_bits_o <= 4'h5 + {2'h0, res_code};
      case (res_code)
        2'h0: begin
          microstep_o <= {3'h0, position_i[4:0]};
          fullstep_o  <= position_i[13:5];
        end
        2'h1: begin
          microstep_o <= {2'h0, position_i[5:0]};
          fullstep_o  <= {1'b0, position_i[13:6]};
        end
        2'h2: begin
          microstep_o <= {1'b0, position_i[6:0]};
          fullstep_o  <= {2'h0, position_i[13:7]};
        end
        default: begin
          microstep_o <= position_i[7:0];
          fullstep_o  <= {3'h0, position_i[13:8]};
        end
      endcase
    end
  end

  // Flag outputs taken from the configuration; encoder-ok is also gated by module-ok.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_mode_o       <= 1'b0;
      trigger_falling_o    <= 1'b0;
      extra_regs_visible_o <= 1'b0;
      lifesign_enabled_o   <= 1'b0;
      encoder_ok_o         <= 1'b0;
    end else begin
      counter_mode_o       <= module_cfg_ff[smc_pkg::MC_COUNTER_MODE_BIT];
      trigger_falling_o    <= sync_cfg_ff[smc_pkg::SC_TRIG_EDGE_BIT];
      extra_regs_visible_o <= sync_info_en;
      lifesign_enabled_o   <= sync_cfg_ff[smc_pkg::SC_LIFESIGN_BIT];
      encoder_ok_o         <= sync_info_en && module_ok_i;
    end
  end

  // ==========================================================================
  // 10 ms time base shared by the settling timer and the turn-off delay.
  logic [22:0] tick_cnt_ff;
  logic        tick;

  assign tick = (tick_cnt_ff == 23'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_ff <= 23'h000000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 23'h000001;
    end
  end

  // ==========================================================================
  // Lifesign shutdown sequence.
  smc_pkg::smc_state_t state_ff;
  smc_pkg::smc_state_t nxt_state;
  logic [11:0] off_cnt_ff;
  logic        trip;
  logic        off_done;

  // Monitoring only counts while the controller has sync configuration bit 6 set.
  assign trip     = sync_cfg_ff[smc_pkg::SC_LIFESIGN_BIT] && lifesign_expired_i;
  assign off_done = (off_cnt_ff == 12'h000);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      smc_pkg::ST_RUN: begin
        if (trip) begin
          nxt_state = smc_pkg::ST_DECEL;
        end
      end
      smc_pkg::ST_DECEL: begin
        if (motor_standstill_i) begin
          nxt_state = smc_pkg::ST_DELAY;
        end
      end
      smc_pkg::ST_DELAY: begin
        if (off_done) begin
          nxt_state = smc_pkg::ST_OFF;
        end
      end
      smc_pkg::ST_OFF: begin
        if (restart_pulse) begin
          nxt_state = smc_pkg::ST_RUN;
        end
      end
      default: nxt_state = smc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= smc_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Delay counted in 10 ms ticks; 100 ms units keep it within 12 bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_cnt_ff <= 12'h000;
    end else if (state_ff == smc_pkg::ST_DECEL) begin
      off_cnt_ff <= 12'({4'h0, turn_off_ff} * smc_pkg::TICKS_PER_OFF_UNIT);
    end else if (state_ff == smc_pkg::ST_DELAY && tick && !off_done) begin
      off_cnt_ff <= off_cnt_ff - 12'h001;
    end
  end

  // Speed-zero request and switch-off follow the sequence state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_zero_o <= 1'b0;
      motor_off_o  <= 1'b0;
    end else begin
      speed_zero_o <= (nxt_state != smc_pkg::ST_RUN);
      motor_off_o  <= (nxt_state == smc_pkg::ST_OFF);
    end
  end

  // ==========================================================================
  // Settling timer: drive-ok only after the full settling time while energised.
  logic [7:0] settle_cnt_ff;
  logic       powered;

  assign powered = motor_energised_i && (state_ff != smc_pkg::ST_OFF);

  // The first tick may land early, so one extra unit is counted to stay a minimum.
  always_ff @(posedge clk_i) begin
    if (rst_i || !powered) begin
      settle_cnt_ff <= 8'h00;
      drive_ok_o    <= 1'b0;
    end else if (tick && !drive_ok_o) begin
      if (settle_cnt_ff == settle_ff) begin
        drive_ok_o <= 1'b1;
      end else begin
        settle_cnt_ff <= settle_cnt_ff + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Current selection: 00 automatic by motion phase, 01 holding, 10 nominal, 11 maximum.
  logic [1:0] cur_sel;
  logic [7:0] auto_cur;

  assign cur_sel = sync_info_en ? sync_cur_sel_ff : setting_current_sel_i;

  always_comb begin
    if (motor_accelerating_i) begin
      auto_cur = max_cur_ff;
    end else if (motor_standstill_i) begin
      auto_cur = hold_cur_ff;
    end else begin
      auto_cur = nom_cur_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_pct_o <= 8'h00;
    end else if (nxt_state == smc_pkg::ST_OFF) begin
      current_pct_o <= 8'h00;
    end else if (nxt_state != smc_pkg::ST_RUN) begin
      current_pct_o <= nom_cur_ff;
    end else begin
      case (cur_sel)
        2'h1:    current_pct_o <= hold_cur_ff;
        2'h2:    current_pct_o <= nom_cur_ff;
        2'h3:    current_pct_o <= max_cur_ff;
        default: current_pct_o <= auto_cur;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt events; a new event in the clearing cycle survives the clear.
  logic               drive_ok_q_ff;
  logic [IRQ_W_C-1:0] irq_event;
  logic [IRQ_W_C-1:0] irq_clear;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_ok_q_ff <= 1'b0;
    end else begin
      drive_ok_q_ff <= drive_ok_o;
    end
  end

  assign irq_event[smc_pkg::IRQ_DRIVE_OK]  = drive_ok_o && !drive_ok_q_ff;
  assign irq_event[smc_pkg::IRQ_TRIP]      = (state_ff == smc_pkg::ST_RUN) && trip;
  assign irq_event[smc_pkg::IRQ_MOTOR_OFF] = (state_ff == smc_pkg::ST_DELAY) && off_done;
  assign irq_clear = (wr_en && wb_sel_i[0] && wb_adr_i == smc_pkg::OFS_IRQ_CLEAR)
                     ? wb_dat_i[IRQ_W_C-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_ff <= '0;
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == smc_pkg::OFS_IRQ_ENABLE) begin
      irq_enable_ff <= wb_dat_i[IRQ_W_C-1:0];
    end
  end

  assign irq_o = |(irq_status_ff & irq_enable_ff);

  // ==========================================================================
  // Read data, registered with the ack; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      if (wb_adr_i == smc_pkg::OFS_MODULE_CFG) begin
        rdata_ff <= {16'h0000, module_cfg_ff};
      end else if (wb_adr_i == smc_pkg::OFS_SYNC_CFG) begin
        rdata_ff <= {24'h000000, sync_cfg_ff};
      end else if (wb_adr_i == smc_pkg::OFS_SETTLE) begin
        rdata_ff <= {24'h000000, settle_ff};
      end else if (wb_adr_i == smc_pkg::OFS_TURN_OFF) begin
        rdata_ff <= {24'h000000, turn_off_ff};
      end else if (wb_adr_i == smc_pkg::OFS_HOLD_CUR || wb_adr_i == smc_pkg::OFS_HOLD_RB) begin
        rdata_ff <= {24'h000000, hold_cur_ff};
      end else if (wb_adr_i == smc_pkg::OFS_NOM_CUR || wb_adr_i == smc_pkg::OFS_NOM_RB) begin
        rdata_ff <= {24'h000000, nom_cur_ff};
      end else if (wb_adr_i == smc_pkg::OFS_MAX_CUR || wb_adr_i == smc_pkg::OFS_MAX_RB) begin
        rdata_ff <= {24'h000000, max_cur_ff};
      end else if (wb_adr_i == smc_pkg::OFS_CONTROL) begin
        rdata_ff <= {30'h00000000, sync_cur_sel_ff};
      end else if (wb_adr_i == smc_pkg::OFS_STATE) begin
        rdata_ff <= {20'h00000, state_ff, 1'b0, speed_zero_o, motor_off_o,
                     encoder_ok_o, module_ok_i, drive_ok_o, trip, sync_info_en};
      end else if (wb_adr_i == smc_pkg::OFS_IRQ_STATUS) begin
        rdata_ff <= {29'h00000000, irq_status_ff};
      end else if (wb_adr_i == smc_pkg::OFS_IRQ_ENABLE) begin
        rdata_ff <= {29'h00000000, irq_enable_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire
